/* include/spi_unit_map.vh */
`ifndef SPI_UNIT_MAP_VH
`define SPI_UNIT_MAP_VH

// ----------------------------------------------------------------
// reset values of control bits
// ----------------------------------------------------------------
`define RST_MASTER_SELECT 1'b1
`define RST_CLOCK_PHASE 1'b1
`define RST_CLOCK_POLARITY 1'b0

// ----------------------------------------------------------------
// master half-period in bus cycles per rate select
// ----------------------------------------------------------------
`define HALF_RATE0 5'h01
`define HALF_RATE1 5'h04
`define HALF_RATE2 5'h08
`define HALF_RATE3 5'h10

// ----------------------------------------------------------------
// transfer geometry
// ----------------------------------------------------------------
`define BITS_PER_BYTE 4'h8
`endif

/* rtl/spi_unit.v */
`include "spi_unit_map.vh"

module spi_unit (
	// clock and reset
	input wire clk_sys,
	input wire arst_n,
	// cpu side
	input wire wait_mode,
	input wire break_mode,
	input wire break_flag_clear_enable,
	input wire ctrl_wr,
	input wire ctl_unit_enable,
	input wire ctl_master_select,
	input wire ctl_clock_polarity_select,
	input wire ctl_clock_phase_select,
	input wire ctl_wired_or_mode,
	input wire ctl_rx_irq_enable,
	input wire ctl_tx_irq_enable,
	input wire ctl_error_irq_enable,
	input wire ctl_mode_fault_enable,
	input wire ctl_rate_select_hi,
	input wire ctl_rate_select_lo,
	input wire status_rd,
	input wire data_wr,
	input wire [7:0] data_wdata,
	input wire data_rd,
	// cpu visible state
	output reg [7:0] rx_data,
	output reg unit_enable,
	output reg tx_empty_flag,
	output reg rx_full_flag,
	output reg overrun_flag,
	output reg mode_fault_flag,
	output reg irq_req,
	// port ownership
	output reg pins_port_owned,
	output reg ss_port_owned,
	// serial pins
	input wire sclk_in,
	output reg sclk_out,
	output reg sclk_oe,
	input wire mosi_in,
	output reg mosi_out,
	output reg mosi_oe,
	input wire miso_in,
	output reg miso_out,
	output reg miso_oe,
	input wire ss_n_in
);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	reg master_select;
	reg clock_polarity_select;
	reg clock_phase_select;
	reg wired_or_mode;
	reg rx_irq_enable;
	reg tx_irq_enable;
	reg error_irq_enable;
	reg mode_fault_enable;
	reg rate_select_hi;
	reg rate_select_lo;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg sclk_m_reg, sclk_s_reg, sclk_d_reg;
	reg mosi_m_reg, mosi_s_reg;
	reg miso_m_reg, miso_s_reg;
	reg ss_m_reg, ss_s_reg, ss_d_reg;

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sclk_m_reg <= 1'b0;
			sclk_s_reg <= 1'b0;
			sclk_d_reg <= 1'b0;
			mosi_m_reg <= 1'b1;
			mosi_s_reg <= 1'b1;
			miso_m_reg <= 1'b1;
			miso_s_reg <= 1'b1;
			ss_m_reg <= 1'b1;
			ss_s_reg <= 1'b1;
			ss_d_reg <= 1'b1;
		end else begin
			sclk_m_reg <= sclk_in;
			sclk_s_reg <= sclk_m_reg;
			sclk_d_reg <= sclk_s_reg;
			mosi_m_reg <= mosi_in;
			mosi_s_reg <= mosi_m_reg;
			miso_m_reg <= miso_in;
			miso_s_reg <= miso_m_reg;
			ss_m_reg <= ss_n_in;
			ss_s_reg <= ss_m_reg;
			ss_d_reg <= ss_s_reg;
		end
	end

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	function [4:0] half_limit;
		input [1:0] rate;
		begin
			case (rate)
				2'b00: half_limit = `HALF_RATE0;
				2'b01: half_limit = `HALF_RATE1;
				2'b10: half_limit = `HALF_RATE2;
				default: half_limit = `HALF_RATE3;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// transfer state
	// ----------------------------------------------------------------
	reg [7:0] tx_buf_reg;
	reg [7:0] shift_reg;
	reg cap_reg;
	reg dout_reg;
	reg [3:0] bit_cnt_reg;
	reg active_reg;
	reg sclk_lvl_reg;
	reg [4:0] half_cnt_reg;
	reg rx_seen_reg;
	reg ovr_seen_reg;
	reg mode_fault_flag_seen_reg;

	wire is_master = unit_enable & master_select;
	wire is_slave = unit_enable & ~master_select;
	wire cpu_ok = ~wait_mode;
	wire brk_block = break_mode & ~break_flag_clear_enable;
	wire wr_ok = cpu_ok & data_wr & ~brk_block;
	wire [1:0] rate_sel = {rate_select_hi, rate_select_lo};
	wire [4:0] half_end = half_limit(rate_sel) - 5'h01;
	wire m_tick = is_master & active_reg & (half_cnt_reg == half_end);
	wire m_lead = m_tick & (~sclk_lvl_reg != clock_polarity_select);
	wire m_trail = m_tick & (~sclk_lvl_reg == clock_polarity_select);
	wire s_sel = is_slave & ~ss_s_reg;
	wire s_chg = s_sel & (sclk_s_reg != sclk_d_reg);
	wire s_lead = s_chg & (sclk_s_reg != clock_polarity_select);
	wire s_trail = s_chg & (sclk_s_reg == clock_polarity_select) & active_reg;
	wire ss_fall = is_slave & ss_d_reg & ~ss_s_reg;
	wire ss_rise = is_slave & ~ss_d_reg & ss_s_reg;
	wire lead = m_lead | s_lead;
	wire trail = m_trail | s_trail;
	wire din = master_select ? miso_s_reg : mosi_s_reg;
	wire done = trail & (bit_cnt_reg == `BITS_PER_BYTE - 4'h1);
	wire idle_after = ~active_reg | done;
	wire load = unit_enable & ~tx_empty_flag & idle_after;
	wire m_fault = is_master & mode_fault_enable & ~ss_s_reg;
	wire s_fault = mode_fault_enable & ss_rise & active_reg;
	wire fault = m_fault | s_fault;
	wire [7:0] shifted = {shift_reg[6:0], clock_phase_select ? din : cap_reg};

	// ----------------------------------------------------------------
	// control bits, system reset only, except unit_enable, which a master mode fault also clears
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			unit_enable <= 1'b0;
			master_select <= `RST_MASTER_SELECT;
			clock_polarity_select <= `RST_CLOCK_POLARITY;
			clock_phase_select <= `RST_CLOCK_PHASE;
			wired_or_mode <= 1'b0;
			rx_irq_enable <= 1'b0;
			tx_irq_enable <= 1'b0;
			error_irq_enable <= 1'b0;
			mode_fault_enable <= 1'b0;
			rate_select_hi <= 1'b0;
			rate_select_lo <= 1'b0;
		end else begin
			if (cpu_ok & ctrl_wr) begin
				unit_enable <= ctl_unit_enable;
				master_select <= ctl_master_select;
				clock_polarity_select <= ctl_clock_polarity_select;
				clock_phase_select <= ctl_clock_phase_select;
				wired_or_mode <= ctl_wired_or_mode;
				rx_irq_enable <= ctl_rx_irq_enable;
				tx_irq_enable <= ctl_tx_irq_enable;
				error_irq_enable <= ctl_error_irq_enable;
				mode_fault_enable <= ctl_mode_fault_enable;
				rate_select_hi <= ctl_rate_select_hi;
				rate_select_lo <= ctl_rate_select_lo;
			end
			if (m_fault)
				unit_enable <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// flags and receive register
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rx_data <= 8'h00;
			rx_full_flag <= 1'b0;
			overrun_flag <= 1'b0;
			mode_fault_flag <= 1'b0;
			rx_seen_reg <= 1'b0;
			ovr_seen_reg <= 1'b0;
			mode_fault_flag_seen_reg <= 1'b0;
			tx_empty_flag <= 1'b1;
			tx_buf_reg <= 8'h00;
		end else begin
			if (cpu_ok & status_rd) begin
				rx_seen_reg <= rx_full_flag;
				ovr_seen_reg <= overrun_flag;
				mode_fault_flag_seen_reg <= mode_fault_flag;
			end
			if (cpu_ok & data_rd & rx_seen_reg) begin
				rx_full_flag <= 1'b0;
				rx_seen_reg <= 1'b0;
			end
			if (cpu_ok & data_rd & ovr_seen_reg) begin
				overrun_flag <= 1'b0;
				ovr_seen_reg <= 1'b0;
			end
			if (cpu_ok & ctrl_wr & mode_fault_flag_seen_reg & ~fault) begin
				mode_fault_flag <= 1'b0;
				mode_fault_flag_seen_reg <= 1'b0;
			end
			if (done) begin
				if (rx_full_flag & ~(cpu_ok & data_rd & rx_seen_reg)) begin
					overrun_flag <= 1'b1;
				end else begin
					rx_data <= shifted;
					rx_full_flag <= 1'b1;
				end
			end
			if (fault)
				mode_fault_flag <= 1'b1;
			if (!unit_enable) begin
				tx_empty_flag <= 1'b1;
			end else if (wr_ok) begin
				tx_buf_reg <= data_wdata;
				tx_empty_flag <= 1'b0;
			end else if (load) begin
				tx_empty_flag <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// shift engine
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			shift_reg <= 8'h00;
			cap_reg <= 1'b0;
			dout_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
			active_reg <= 1'b0;
			sclk_lvl_reg <= 1'b0;
			half_cnt_reg <= 5'h00;
		end else if (!unit_enable) begin
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			active_reg <= 1'b0;
			half_cnt_reg <= 5'h00;
			sclk_lvl_reg <= clock_polarity_select;
			dout_reg <= 1'b0;
		end else begin
			if (m_tick) begin
				sclk_lvl_reg <= ~sclk_lvl_reg;
				half_cnt_reg <= 5'h00;
			end else if (active_reg & is_master) begin
				half_cnt_reg <= half_cnt_reg + 5'h01;
			end
			if (lead) begin
				if (clock_phase_select)
					dout_reg <= shift_reg[7];
				else
					cap_reg <= din;
				if (is_slave)
					active_reg <= 1'b1;
			end
			if (trail) begin
				shift_reg <= shifted;
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				if (!clock_phase_select)
					dout_reg <= shift_reg[6];
			end
			if (ss_fall & ~clock_phase_select) begin
				active_reg <= 1'b1;
				dout_reg <= load ? tx_buf_reg[7] : shift_reg[7];
			end
			if (done) begin
				bit_cnt_reg <= 4'h0;
				active_reg <= 1'b0;
				if (is_slave)
					dout_reg <= shifted[7];
			end
			if (load) begin
				shift_reg <= tx_buf_reg;
				bit_cnt_reg <= 4'h0;
				if (!clock_phase_select)
					dout_reg <= tx_buf_reg[7];
				if (is_master) begin
					active_reg <= 1'b1;
					half_cnt_reg <= 5'h00;
					sclk_lvl_reg <= clock_polarity_select;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// pin drivers and ownership
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sclk_out <= 1'b0;
			sclk_oe <= 1'b0;
			mosi_out <= 1'b0;
			mosi_oe <= 1'b0;
			miso_out <= 1'b0;
			miso_oe <= 1'b0;
			pins_port_owned <= 1'b1;
			ss_port_owned <= 1'b1;
			irq_req <= 1'b0;
		end else begin
			pins_port_owned <= ~unit_enable;
			ss_port_owned <= ~unit_enable | (master_select & ~mode_fault_enable);
			sclk_out <= sclk_lvl_reg;
			sclk_oe <= is_master;
			if (wired_or_mode) begin
				mosi_out <= 1'b0;
				mosi_oe <= is_master & ~dout_reg;
			end else begin
				mosi_out <= dout_reg;
				mosi_oe <= is_master;
			end
			miso_out <= dout_reg;
			miso_oe <= is_slave & ~ss_s_reg;
			irq_req <= (rx_irq_enable & rx_full_flag & unit_enable)
				| (tx_irq_enable & tx_empty_flag & unit_enable)
				| (error_irq_enable & (overrun_flag | mode_fault_flag));
		end
	end

endmodule

/* bench/spi_unit_checker.sv */
module spi_unit_checker (
	input wire logic clk_sys, arst_n, wait_mode, break_mode, break_flag_clear_enable, data_wr, data_rd,
	input wire logic [7:0] rx_data,
	input wire logic unit_enable, tx_empty_flag, rx_full_flag, overrun_flag, mode_fault_flag,
	input wire logic pins_port_owned, ss_port_owned, sclk_oe, mosi_oe, miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	sequence wr_taken_s;
		data_wr && !wait_mode && unit_enable && !(break_mode && !break_flag_clear_enable);
	endsequence
	sequence disabled_s;
		!unit_enable [*3];
	endsequence
	release_on_off_a: assert property (disabled_s |-> pins_port_owned && ss_port_owned && tx_empty_flag)
		else $error("pins or tx empty not released while disabled");
	port_drivers_off_a: assert property (pins_port_owned [*2] |-> !sclk_oe && !mosi_oe && !miso_oe)
		else $error("pin driven while port owned");
	write_clears_a: assert property (wr_taken_s ##0 tx_empty_flag |=> !tx_empty_flag)
		else $error("accepted write left tx empty set");
	empty_fall_cause_a: assert property ($fell(tx_empty_flag) |-> $past(data_wr && !wait_mode && unit_enable
		&& !(break_mode && !break_flag_clear_enable)))
		else $error("tx empty cleared without accepted write");
	rx_clear_cause_a: assert property ($fell(rx_full_flag) |-> $past(data_rd && !wait_mode))
		else $error("rx full cleared without data read");
	overrun_keep_a: assert property ($rose(overrun_flag) |-> $past(rx_full_flag) && $stable(rx_data))
		else $error("overrun without full register or data changed");
	fault_disables_a: assert property ($rose(mode_fault_flag) && $past(sclk_oe) |-> ##[0:2] !unit_enable)
		else $error("master fault did not disable");
	one_driver_a: assert property (sclk_oe |-> !miso_oe)
		else $error("clock and slave data driven together");
endmodule
bind spi_unit spi_unit_checker i_spi_unit_checker (.clk_sys, .arst_n, .wait_mode, .break_mode,
	.break_flag_clear_enable, .data_wr, .data_rd, .rx_data, .unit_enable, .tx_empty_flag, .rx_full_flag,
	.overrun_flag, .mode_fault_flag, .pins_port_owned, .ss_port_owned, .sclk_oe, .mosi_oe, .miso_oe);

/* bench/spi_far_slave.sv */
module spi_far_slave (
	input wire logic sclk, mosi,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	int n = 0;
	initial miso = 1'b0;
	// leading edge presents next bit, msb first
	always @(posedge sclk) begin
		if (n == 0) sh = tx_byte;
		miso <= sh[7];
		sh = {sh[6:0], 1'b0};
	end
	// trailing edge captures; line inverted after eighth bit
	always @(negedge sclk) begin
		rx_byte <= {rx_byte[6:0], mosi};
		n = (n + 1) % 8;
		if (n == 0) miso <= ~miso;
	end
endmodule

/* bench/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, arst_n = 0, wait_mode = 0, break_mode = 0, break_flag_clear_enable = 0;
	logic ctrl_wr = 0, status_rd = 0, data_wr = 0, data_rd = 0, sclk_drv = 0, mosi_drv = 1, ss_n_drv = 1;
	logic [7:0] data_wdata = 8'h00, far_tx = 8'h00, rx_data, far_rx, got;
	logic [10:0] cfg = 11'h000;
	logic unit_enable, tx_empty_flag, rx_full_flag, overrun_flag, mode_fault_flag, irq_req, far_miso;
	logic pins_port_owned, ss_port_owned, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe;
	int failures = 0, checks = 0;
	wire sclk_w = sclk_oe ? sclk_out : sclk_drv;
	wire mosi_w = mosi_oe ? mosi_out : mosi_drv;
	wire miso_w = miso_oe ? miso_out : far_miso;
	logic [7:0] rows [3][2] = '{'{8'ha5, 8'h3c}, '{8'h01, 8'h80}, '{8'hff, 8'h00}};
	spi_unit i_spi_unit (.clk_sys, .arst_n, .wait_mode, .break_mode, .break_flag_clear_enable, .ctrl_wr,
		.ctl_unit_enable(cfg[10]), .ctl_master_select(cfg[9]), .ctl_clock_polarity_select(cfg[8]),
		.ctl_clock_phase_select(cfg[7]), .ctl_wired_or_mode(cfg[6]), .ctl_rx_irq_enable(cfg[5]),
		.ctl_tx_irq_enable(cfg[4]), .ctl_error_irq_enable(cfg[3]), .ctl_mode_fault_enable(cfg[2]),
		.ctl_rate_select_hi(cfg[1]), .ctl_rate_select_lo(cfg[0]), .status_rd, .data_wr, .data_wdata, .data_rd,
		.rx_data, .unit_enable, .tx_empty_flag, .rx_full_flag, .overrun_flag, .mode_fault_flag, .irq_req,
		.pins_port_owned, .ss_port_owned, .sclk_in(sclk_w), .sclk_out, .sclk_oe, .mosi_in(mosi_w), .mosi_out,
		.mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe, .ss_n_in(ss_n_drv));
	spi_far_slave i_spi_far_slave (.sclk(sclk_w), .mosi(mosi_w), .tx_byte(far_tx), .miso(far_miso),
		.rx_byte(far_rx));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// op bits: ctrl write, status read, data write, data read
	task automatic cpu(input logic [3:0] op, input logic [7:0] d);
		@(posedge clk_sys);
		{ctrl_wr, status_rd, data_wr, data_rd} <= op;
		data_wdata <= d;
		@(posedge clk_sys);
		{ctrl_wr, status_rd, data_wr, data_rd} <= 4'h0;
		#1;
	endtask
	task automatic ctl(input logic [10:0] c);
		@(posedge clk_sys);
		cfg <= c;
		cpu(4'h8, 8'h00);
	endtask
	task automatic wait_rx;
		for (int i = 0; i < 3000 && rx_full_flag !== 1'b1; i++) @(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic link_byte(input logic [7:0] dout);
		for (int i = 7; i >= 0; i--) begin
			sclk_drv = 1'b1;
			mosi_drv = dout[i];
			#62.5;
			sclk_drv = 1'b0;
			got[i] = miso_w;
			#62.5;
		end
	endtask
	task automatic print_verdict;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial forever #2 clk_sys = ~clk_sys;
	initial begin
		#200us;
		failures++;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		#1;
		chk("tx_empty", 1, tx_empty_flag);
		chk("pins_owned", 1, pins_port_owned);
		chk("ss_owned", 1, ss_port_owned);
		ctl(11'h68a);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("pins_owned", 0, pins_port_owned);
		chk("ss_owned", 1, ss_port_owned);
		foreach (rows[i]) begin
			far_tx = rows[i][1];
			cpu(4'h2, rows[i][0]);
			wait_rx;
			chk("rx_data", rows[i][1], rx_data);
			chk("far_rx", rows[i][0], far_rx);
			cpu(4'h4, 8'h00);
			cpu(4'h1, 8'h00);
			chk("rx_full", 0, rx_full_flag);
		end
		far_tx = 8'h96;
		cpu(4'h2, 8'hc3);
		chk("tx_empty", 0, tx_empty_flag);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("tx_empty", 1, tx_empty_flag);
		cpu(4'h2, 8'h69);
		wait_rx;
		far_tx = 8'h5a;
		chk("tx_empty", 1, tx_empty_flag);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("tx_empty", 1, tx_empty_flag);
		for (int i = 0; i < 3000 && overrun_flag !== 1'b1; i++) @(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("rx_data", 8'h96, rx_data);
		chk("far_rx", 8'h69, far_rx);
		wait_mode <= 1'b1;
		cpu(4'h2, 8'h55);
		chk("tx_empty", 1, tx_empty_flag);
		chk("irq_req", 1, irq_req);
		wait_mode <= 1'b0;
		ctl(11'h08a);
		chk("rx_full", 1, rx_full_flag);
		chk("overrun", 1, overrun_flag);
		@(posedge clk_sys);
		#1;
		chk("pins_owned", 1, pins_port_owned);
		ctl(11'h68a);
		break_mode <= 1'b1;
		cpu(4'h2, 8'h11);
		chk("tx_empty", 1, tx_empty_flag);
		break_mode <= 1'b0;
		cpu(4'h4, 8'h00);
		cpu(4'h1, 8'h00);
		chk("overrun", 0, overrun_flag);
		ctl(11'h68e);
		ss_n_drv <= 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
		chk("enable", 0, unit_enable);
		chk("fault", 1, mode_fault_flag);
		chk("pins_owned", 1, pins_port_owned);
		ss_n_drv <= 1'b1;
		ctl(11'h480);
		repeat (6) @(posedge clk_sys);
		#1;
		chk("miso_oe", 0, miso_oe);
		chk("ss_owned", 0, ss_port_owned);
		cpu(4'h2, 8'h3c);
		ss_n_drv <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		chk("miso_oe", 1, miso_oe);
		link_byte(8'ha6);
		wait_rx;
		chk("rx_data", 8'ha6, rx_data);
		chk("miso_data", 8'h3c, got);
		cpu(4'h4, 8'h00);
		cpu(4'h1, 8'h00);
		ss_n_drv <= 1'b1;
		repeat (6) @(posedge clk_sys);
		link_byte(8'hff);
		repeat (20) @(posedge clk_sys);
		#1;
		chk("rx_full", 0, rx_full_flag);
		ctl(11'h6ca);
		far_tx = 8'h5a;
		cpu(4'h2, 8'h4b);
		wait_rx;
		chk("far_rx", 8'h4b, far_rx);
		chk("rx_data", 8'h5a, rx_data);
		chk("mosi_out", 0, mosi_out);
		print_verdict;
	end
endmodule
